// ---- sspwm_pkg.sv ----
// constants for the soft-start pwm timing block
package sspwm_pkg;
    localparam int CLK_HZ          = 100_000_000;
    localparam int SW_HZ           = 65_000;
    localparam int JIT_PCT         = 4;
    localparam int DMAX_NUM        = 3;
    localparam int DMAX_DEN        = 4;
    localparam int SS_STEPS        = 32;
    localparam int SS_STEP_US      = 300;
    localparam int SS_TOTAL_MS     = 10;
    localparam int JIT_PERIOD_MS   = 4;
    localparam int BLANK_NORM_NS   = 220;
    localparam int BLANK_BURST_NS  = 180;
    localparam int ON_DELAY_NS     = 156;
    // derived cycle counts
    localparam int PERIOD_CYC      = (CLK_HZ + SW_HZ / 2) / SW_HZ;
    localparam int JIT_CYC         = PERIOD_CYC * JIT_PCT / 100;
    localparam int MAX_ON_CYC      = PERIOD_CYC * DMAX_NUM / DMAX_DEN;
    localparam int SS_STEP_CYC     = SS_STEP_US * (CLK_HZ / 1_000_000);
    localparam int SS_TOTAL_CYC    = SS_TOTAL_MS * (CLK_HZ / 1_000);
    localparam int JIT_TOTAL_CYC   = JIT_PERIOD_MS * (CLK_HZ / 1_000);
    localparam int JIT_STEP_CYC    = JIT_TOTAL_CYC / (4 * JIT_CYC);
    localparam int BLANK_NORM_CYC  = (BLANK_NORM_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int BLANK_BURST_CYC = (BLANK_BURST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ON_DELAY_CYC    = ON_DELAY_NS * (CLK_HZ / 1_000_000) / 1000;
    localparam int CNT_W           = 12;
    localparam int LVL_W           = 5;
    localparam logic [LVL_W-1:0] LVL_RESET = 5'h00;
    typedef enum logic [1:0] {
        SSPWM_OFF  = 2'b00,
        SSPWM_SOFT = 2'b01,
        SSPWM_RUN  = 2'b11
    } sspwm_state_e;
endpackage : sspwm_pkg

// ---- sspwm_core.sv ----
// soft-start sequencer, jittered oscillator and pwm latch with current limits
`timescale 1ns/1ps
// How it works
// - soft start begins when supply passes turn-on
// - level steps every 300us, 32 steps
// - soft start ends 10ms after turn-on
// - permitted duty rises from zero to maximum
// - every auto-restart attempt reruns soft start
// - 65kHz clock swept plus/minus 4% per 4ms
// - on-time never exceeds 0.75 of the nominal period
// - jitter only after soft start completes
// - oscillator sets latch; comparators reset it
// - latch reset turns gate off immediately
// - gate held low during undervoltage lockout
// - peak comparator ends on-time each cycle
// - sense ignored 220ns normal, 180ns burst
// - burst limit comparator enabled only in burst
// - steep slope selects earlier switch-off threshold
// - supply above turn-on leaves startup
// - supply below turn-off clears soft-start counter
// - gate held off about 156ns after trigger
module sspwm_core
    import sspwm_pkg::*;
#(
    parameter int SS_STEP  = SS_STEP_CYC,
    parameter int SS_TOTAL = SS_TOTAL_CYC,
    parameter int JIT_STEP = JIT_STEP_CYC
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_ce,
    input  wire logic             i_supply_on,
    input  wire logic             i_supply_low,
    input  wire logic             i_restart,
    input  wire logic             i_burst_mode,
    input  wire logic             i_fb_trip,
    input  wire logic             i_ss_trip,
    input  wire logic             i_peak_trip,
    input  wire logic             i_peak_early_trip,
    input  wire logic             i_steep_slope,
    input  wire logic             i_burst_trip,
    output logic                  o_gate,
    output logic                  o_oscillator_pulse,
    output logic [LVL_W-1:0]      o_soft_start_level,
    output logic                  o_soft_start_active,
    output logic                  o_burst_limit_gate,
    output logic                  o_leading_edge_blanking
);
    localparam int NI = 9;
    logic [NI-1:0] meta_r, sync_r, meta_nxt, sync_nxt;
    logic s_on, s_low, s_rst, s_burst, s_fb, s_ss, s_pk, s_pke, s_steep, s_btrip;
    logic rst_d_r, rst_d_nxt;
    sspwm_state_e state_r, state_nxt;
    logic [19:0] ss_tmr_r, ss_tmr_nxt, step_tmr_r, step_tmr_nxt, jit_tmr_r, jit_tmr_nxt;
    logic [LVL_W-1:0] lvl_r, lvl_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt, len_r, len_nxt;
    logic [7:0] jit_r, jit_nxt;
    logic jit_up_r, jit_up_nxt;
    logic latch_r, latch_nxt, gate_nxt, osc_nxt, blank_nxt, window, wrap, trip;
    logic [CNT_W-1:0] blank_len;

    function automatic logic reached(input logic [19:0] v, input int lim);
        reached = (v >= 20'(lim - 1));
    endfunction : reached

    // two-flop synchronisers on every analog status input
    always_comb begin
        meta_nxt = {i_supply_on, i_supply_low, i_restart, i_burst_mode, i_fb_trip,
                    i_ss_trip, i_peak_trip, i_peak_early_trip, i_steep_slope};
        sync_nxt = meta_r;
    end
    assign {s_on, s_low, s_rst, s_burst, s_fb, s_ss, s_pk, s_pke, s_steep} = sync_r;
    logic [1:0] bt_r, bt_nxt;
    always_comb bt_nxt = {bt_r[0], i_burst_trip};
    assign s_btrip = bt_r[1];

    // start-up, soft start and restart sequencing
    always_comb begin
        state_nxt    = state_r;
        ss_tmr_nxt   = ss_tmr_r;
        step_tmr_nxt = step_tmr_r;
        lvl_nxt      = lvl_r;
        rst_d_nxt    = s_rst;
        case (state_r)
            SSPWM_OFF: begin
                ss_tmr_nxt   = '0;
                step_tmr_nxt = '0;
                lvl_nxt      = LVL_RESET;
                if (s_on) state_nxt = SSPWM_SOFT;
            end
            SSPWM_SOFT: begin
                ss_tmr_nxt = ss_tmr_r + 20'd1;
                if (reached(step_tmr_r, SS_STEP)) begin
                    step_tmr_nxt = '0;
                    if (lvl_r != LVL_W'(SS_STEPS - 1)) lvl_nxt = lvl_r + 1'b1;
                end else begin
                    step_tmr_nxt = step_tmr_r + 20'd1;
                end
                if (reached(ss_tmr_r, SS_TOTAL)) state_nxt = SSPWM_RUN;
            end
            SSPWM_RUN: state_nxt = SSPWM_RUN;
            default:   state_nxt = SSPWM_OFF;
        endcase
        if (s_rst && !rst_d_r && state_r != SSPWM_OFF) begin
            state_nxt    = SSPWM_SOFT;
            ss_tmr_nxt   = '0;
            step_tmr_nxt = '0;
            lvl_nxt      = LVL_RESET;
        end
        if (s_low) begin
            state_nxt    = SSPWM_OFF;
            ss_tmr_nxt   = '0;
            step_tmr_nxt = '0;
            lvl_nxt      = LVL_RESET;
        end
    end

    // oscillator with triangular jitter of the period length
    always_comb begin
        jit_tmr_nxt = jit_tmr_r;
        jit_nxt     = jit_r;
        jit_up_nxt  = jit_up_r;
        if (state_r == SSPWM_RUN) begin
            if (reached(jit_tmr_r, JIT_STEP)) begin
                jit_tmr_nxt = '0;
                if (jit_up_r) begin
                    jit_nxt = jit_r + 8'd1;
                    if (jit_r == 8'(2 * JIT_CYC - 1)) jit_up_nxt = 1'b0;
                end else begin
                    jit_nxt = jit_r - 8'd1;
                    if (jit_r == 8'd1) jit_up_nxt = 1'b1;
                end
            end else begin
                jit_tmr_nxt = jit_tmr_r + 20'd1;
            end
        end else begin
            jit_tmr_nxt = '0;
            jit_nxt     = 8'(JIT_CYC);
            jit_up_nxt  = 1'b1;
        end
        wrap    = (cnt_r >= len_r - 1'b1);
        cnt_nxt = wrap ? '0 : cnt_r + 1'b1;
        len_nxt = wrap ? CNT_W'(PERIOD_CYC - JIT_CYC) + CNT_W'(jit_r) : len_r;
        osc_nxt = wrap;
    end

    // pwm latch, blanking and limit comparators
    always_comb begin
        blank_len = s_burst ? CNT_W'(BLANK_BURST_CYC) : CNT_W'(BLANK_NORM_CYC);
        window    = (cnt_nxt >= CNT_W'(ON_DELAY_CYC)) && (cnt_nxt < CNT_W'(MAX_ON_CYC));
        blank_nxt = (cnt_nxt >= CNT_W'(ON_DELAY_CYC))
                    && (cnt_nxt < CNT_W'(ON_DELAY_CYC) + blank_len);
        trip      = s_fb
                    || (s_ss && state_r == SSPWM_SOFT)
                    || (s_steep ? s_pke : s_pk)
                    || (s_burst && s_btrip);
        latch_nxt = latch_r;
        if (wrap) latch_nxt = 1'b1;
        else if (trip && !o_leading_edge_blanking) latch_nxt = 1'b0;
        if (state_nxt == SSPWM_OFF) latch_nxt = 1'b0;
        gate_nxt = latch_nxt && window && state_nxt != SSPWM_OFF;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            meta_r <= '0; sync_r <= '0; bt_r <= '0; rst_d_r <= 1'b0;
            state_r <= SSPWM_OFF;
            ss_tmr_r <= '0; step_tmr_r <= '0; jit_tmr_r <= '0;
            lvl_r <= LVL_RESET;
            jit_r <= 8'(JIT_CYC); jit_up_r <= 1'b1;
            cnt_r <= '0; len_r <= CNT_W'(PERIOD_CYC);
            latch_r <= 1'b0; o_gate <= 1'b0; o_oscillator_pulse <= 1'b0;
            o_leading_edge_blanking <= 1'b0;
            o_soft_start_level <= LVL_RESET; o_soft_start_active <= 1'b0;
            o_burst_limit_gate <= 1'b0;
        end else if (i_ce) begin
            meta_r <= meta_nxt; sync_r <= sync_nxt; bt_r <= bt_nxt; rst_d_r <= rst_d_nxt;
            state_r <= state_nxt;
            ss_tmr_r <= ss_tmr_nxt; step_tmr_r <= step_tmr_nxt; jit_tmr_r <= jit_tmr_nxt;
            lvl_r <= lvl_nxt;
            jit_r <= jit_nxt; jit_up_r <= jit_up_nxt;
            cnt_r <= cnt_nxt; len_r <= len_nxt;
            latch_r <= latch_nxt; o_gate <= gate_nxt; o_oscillator_pulse <= osc_nxt;
            o_leading_edge_blanking <= blank_nxt;
            o_soft_start_level <= lvl_nxt;
            o_soft_start_active <= (state_nxt == SSPWM_SOFT);
            o_burst_limit_gate <= s_burst;
        end
    end

    // checks
    gate_uvlo_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_r == SSPWM_OFF |-> !o_gate) else $error("gate on in lockout");
    max_duty_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_gate |-> cnt_r < CNT_W'(MAX_ON_CYC)) else $error("duty above limit");
    on_delay_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        $rose(o_oscillator_pulse) |-> !o_gate [*8]) else $error("gate during hold-off");
    trip_off_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && o_gate && !o_leading_edge_blanking && s_fb && !wrap |=> !o_gate)
        else $error("gate stayed on after trip");
    blank_hold_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && o_gate && o_leading_edge_blanking && window && !wrap
        && state_nxt != SSPWM_OFF |=> o_gate)
        else $error("gate cut while blanked");
    low_clear_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && s_low |=> lvl_r == LVL_RESET && state_r == SSPWM_OFF)
        else $error("counter not cleared");
    start_soft_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        i_ce && state_r == SSPWM_OFF && s_on && !s_low |=> state_r == SSPWM_SOFT)
        else $error("soft start not begun");
    fixed_freq_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        state_r != SSPWM_RUN && $stable(state_r) && osc_nxt |=> len_r == CNT_W'(PERIOD_CYC))
        else $error("jitter in soft start");
    jit_range_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
        jit_r <= 8'(2 * JIT_CYC)) else $error("jitter out of range");
endmodule : sspwm_core

// ---- sspwm_switch_model.sv ----
// current ramp model of the power switch, sense resistor and feedback network
`timescale 1ns/1ps
module sspwm_switch_model (
    input  wire logic        i_clk,
    input  wire logic        i_gate,
    input  wire logic [10:0] i_peak_lim,
    input  wire logic [10:0] i_fb_lim,
    input  wire logic [10:0] i_ss_lim,
    input  wire logic [10:0] i_burst_lim,
    output logic             o_peak_trip,
    output logic             o_peak_early_trip,
    output logic             o_fb_trip,
    output logic             o_ss_trip,
    output logic             o_burst_trip
);
    logic [10:0] ramp_r = 11'h000;
    // current rises only while the switch conducts
    always @(negedge i_clk) begin
        ramp_r <= i_gate ? ramp_r + 11'h001 : 11'h000;
    end
    assign o_peak_trip       = ramp_r >= i_peak_lim;
    // lower threshold for a steep slope
    assign o_peak_early_trip = ramp_r + 11'h008 >= i_peak_lim;
    assign o_fb_trip         = ramp_r >= i_fb_lim;
    assign o_ss_trip         = ramp_r >= i_ss_lim;
    assign o_burst_trip      = ramp_r >= i_burst_lim;
endmodule : sspwm_switch_model

// ---- sspwm_core_test.sv ----
// self-checking bench for the soft-start pwm core
`timescale 1ns/1ps
module sspwm_core_test;
    import sspwm_pkg::*;
    typedef struct {int plo; int phi; int olo; int ohi;} sspwm_note_s;
    logic             clk = 1'b0;
    logic             reset_n = 1'b0;
    logic             ce = 1'b1;
    logic [9:0]       snap;
    logic             sup_on = 1'b0, sup_low = 1'b0, restart = 1'b0, burst = 1'b0, steep = 1'b0;
    logic [10:0]      pk_lim = 11'h7ff, fb_lim = 11'h7ff, ss_lim = 11'h028, bu_lim = 11'h7ff;
    logic             fb_t, ss_t, pk_t, early_t, bu_t, gate, pulse, active, bgate, blank;
    logic [LVL_W-1:0] level;
    sspwm_note_s      notes[$];
    int               mismatches = 0, tests_run = 0, per_cnt = 0, on_cnt = 0, blk_cnt = 0, lim;
    time              t0;
    sspwm_core #(.SS_STEP(200), .SS_TOTAL(12000), .JIT_STEP(4)) i_sspwm_core (
        .i_clk(clk), .i_reset_n(reset_n), .i_ce(ce), .i_supply_on(sup_on),
        .i_supply_low(sup_low), .i_restart(restart), .i_burst_mode(burst),
        .i_fb_trip(fb_t), .i_ss_trip(ss_t), .i_peak_trip(pk_t), .i_peak_early_trip(early_t),
        .i_steep_slope(steep), .i_burst_trip(bu_t), .o_gate(gate), .o_oscillator_pulse(pulse),
        .o_soft_start_level(level), .o_soft_start_active(active),
        .o_burst_limit_gate(bgate), .o_leading_edge_blanking(blank));
    sspwm_switch_model i_sspwm_switch_model (
        .i_clk(clk), .i_gate(gate), .i_peak_lim(pk_lim), .i_fb_lim(fb_lim), .i_ss_lim(ss_lim),
        .i_burst_lim(bu_lim), .o_peak_trip(pk_t), .o_peak_early_trip(early_t),
        .o_fb_trip(fb_t), .o_ss_trip(ss_t), .o_burst_trip(bu_t));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error: %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // notes one period's expected length and on-time, waits until it is judged
    task automatic period(input int plo, input int phi, input int olo, input int ohi);
        notes.push_back('{plo, phi, olo, ohi});
        while (notes.size() != 0) @(negedge clk);
    endtask : period
    // measures each period and its on-time, judged at the next period start
    always @(posedge clk) begin
        if (pulse === 1'b1) begin
            if (notes.size() != 0) begin
                tests_run += 3;
                if (per_cnt < notes[0].plo || per_cnt > notes[0].phi) begin
                    mismatches++;
                    $display("Error: period expected %0d..%0d seen %0d", notes[0].plo,
                             notes[0].phi, per_cnt);
                end
                if (on_cnt < notes[0].olo || on_cnt > notes[0].ohi) begin
                    mismatches++;
                    $display("Error: on time expected %0d..%0d seen %0d", notes[0].olo,
                             notes[0].ohi, on_cnt);
                end
                if (blk_cnt != (burst ? BLANK_BURST_CYC : BLANK_NORM_CYC)) begin
                    mismatches++;
                    $display("Error: blanking expected %0d seen %0d",
                             burst ? BLANK_BURST_CYC : BLANK_NORM_CYC, blk_cnt);
                end
                void'(notes.pop_front());
            end
            per_cnt = 1;
            on_cnt = 0;
            blk_cnt = 0;
        end else begin
            per_cnt++;
            if (gate === 1'b1) on_cnt++;
            if (blank === 1'b1) blk_cnt++;
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h7614));
        cyc(16);
        reset_n = 1'b1;
        cyc(200);
        chk("gate", 1'b0, gate);
        chk("level", 5'h00, level);
        sup_on = 1'b1;
        t0 = $time;
        cyc(4);
        chk("soft active", 1'b1, active);
        cyc(96);
        for (int k = 0; k < 32; k++) begin
            chk("level", k[15:0], level);
            cyc(200);
        end
        while (pulse !== 1'b1) @(negedge clk);
        @(negedge clk);
        period(1538, 1538, 40, 45);
        while ($time < t0 + 119000) @(negedge clk);
        chk("soft active", 1'b1, active);
        cyc(200);
        chk("soft active", 1'b0, active);
        chk("level", 5'h1f, level);
        while (pulse !== 1'b1) @(negedge clk);
        @(negedge clk);
        repeat (3) period(1477, 1599, 1130, 1153);
        repeat (3) begin
            lim = 30 + $urandom_range(370);
            pk_lim = lim[10:0];
            period(1477, 1599, lim, lim + 4);
        end
        steep = 1'b1;
        period(1477, 1599, lim - 8, lim - 4);
        steep = 1'b0;
        pk_lim = 11'h7ff;
        fb_lim = lim[10:0];
        period(1477, 1599, lim, lim + 4);
        fb_lim = 11'h7ff;
        pk_lim = 11'h005;
        period(1477, 1599, 22, 27);
        burst = 1'b1;
        period(1477, 1599, 18, 23);
        chk("burst gate", 1'b1, bgate);
        pk_lim = 11'h7ff;
        bu_lim = 11'h03c;
        period(1477, 1599, 60, 64);
        burst = 1'b0;
        period(1477, 1599, 1130, 1153);
        // freeze in mid on-time: without the enable the gate would end at max duty
        cyc(300);
        ce = 1'b0;
        snap = {gate, pulse, active, bgate, blank, level};
        cyc(1000);
        chk("frozen outputs", {6'h00, snap}, {6'h00, gate, pulse, active, bgate, blank, level});
        chk("frozen gate", 1'b1, gate);
        ce = 1'b1;
        restart = 1'b1;
        cyc(5);
        chk("soft active", 1'b1, active);
        chk("level", 5'h00, level);
        restart = 1'b0;
        sup_low = 1'b1;
        sup_on = 1'b0;
        cyc(5);
        chk("soft active", 1'b0, active);
        chk("level", 5'h00, level);
        cyc(2000);
        chk("gate", 1'b0, gate);
        give_verdict();
    end
endmodule : sspwm_core_test
